// file: dout_sink8.sv
// Eight-channel sinking output block: process-image write path, object
// addressing, channel drive, channel LEDs and module run/fault indication.
// Assumes the bus master delivers one-cycle write requests on i_clk and
// that fault sense lines from the power stage are asynchronous pins.
// Hardware faults only light the red indicator; the power stage protects itself.
`default_nettype none

module dout_sink8
   import dout_pkg::*;
#(
   parameter int BLINK_HALF = BLINK_HALF_CYC
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Bus master writes
   input wire wr_req_t i_wr,
   input wire logic [7:0] i_slot,
   output logic o_wr_ack,
   output logic o_wr_err,
   // Identification
   input wire logic i_id_rd,
   output logic o_id_valid,
   output logic [31:0] o_id_data,
   // Input area
   output logic [7:0] o_in_len,
   // Bus status from the interface logic
   input wire bus_stat_t i_bus,
   // Power stage
   input wire logic [CHANNELS-1:0] i_ovl_pin,
   input wire logic [CHANNELS-1:0] i_short_pin,
   input wire logic [CHANNELS-1:0] i_hot_pin,
   output logic [CHANNELS-1:0] o_sink_on,
   // Indicators
   output led_t o_led
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] out;
      logic seen;
      logic ack;
      logic err;
      logic id_valid;
      logic [31:0] id_data;
      logic [31:0] blink_cnt;
      logic blink;
      led_t led;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   logic [CHANNELS-1:0] ovl_s;
   logic [CHANNELS-1:0] short_s;
   logic [CHANNELS-1:0] hot_s;
   logic [15:0] ec_index;
   logic hw_fault;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Drive and channel indicators stay dark until the first accepted write
   function automatic logic [CHANNELS-1:0] gate_out(input logic [7:0] img, input logic seen);
      return img & {CHANNELS{seen}};
   endfunction : gate_out

   // Bookkeeping shared by every accepted write
   function automatic state_t mark_taken(input state_t s);
      state_t t;
      t = s;
      t.seen = 1'b1;
      t.ack = 1'b1;
      return t;
   endfunction : mark_taken

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   dout_sync u_sync_ovl (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(i_ovl_pin),
      .o_sync(ovl_s)
   );

   dout_sync u_sync_short (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(i_short_pin),
      .o_sync(short_s)
   );

   dout_sync u_sync_hot (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_async(i_hot_pin),
      .o_sync(hot_s)
   );

   // ----------------------------------------------------------------------
   // Derived signals
   // ----------------------------------------------------------------------
   assign ec_index = EC_INDEX_BASE + {8'h00, i_slot};
   // Any synchronised fault line of any channel
   assign hw_fault = |{ovl_s, short_s, hot_s};

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.err = 1'b0;
      st_nxt.id_valid = 1'b0;

      // ----------------------------------------------------------------------
      // Write decode
      // ----------------------------------------------------------------------
      if (i_wr.valid) begin
         case (i_wr.mode)
            WR_IMAGE: begin
               if (i_wr.addr == OUT_OFFSET) begin
                  st_nxt.out = i_wr.data;
                  st_nxt = mark_taken(st_nxt);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            WR_CANOPEN: begin
               if (i_wr.addr == CO_INDEX && i_wr.sub == SUB_WHOLE) begin
                  st_nxt.out = i_wr.data;
                  st_nxt = mark_taken(st_nxt);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            WR_ETHERCAT: begin
               // Single-bit object per channel, value in data bit 0
               if (i_wr.addr == ec_index && sub_in_range(i_wr.sub)) begin
                  st_nxt.out[sub_to_chan(i_wr.sub)] = i_wr.data[0];
                  st_nxt = mark_taken(st_nxt);
               end else begin
                  st_nxt.err = 1'b1;
               end
            end
            default: begin
               st_nxt.err = 1'b1;
            end
         endcase
      end

      // ----------------------------------------------------------------------
      // Identification read, answered one cycle later
      // ----------------------------------------------------------------------
      if (i_id_rd) begin
         st_nxt.id_valid = 1'b1;
         st_nxt.id_data = MODULE_ID;
      end

      // ----------------------------------------------------------------------
      // Blink timebase shared by config error and bus failure
      // ----------------------------------------------------------------------
      if (st_r.blink_cnt >= 32'(BLINK_HALF - 1)) begin
         st_nxt.blink_cnt = BLINK_CNT_RESET;
         st_nxt.blink = ~st_r.blink;
      end else begin
         st_nxt.blink_cnt = st_r.blink_cnt + 32'h0000_0001;
      end

      // ----------------------------------------------------------------------
      // Channel indicators track the driven bit
      // ----------------------------------------------------------------------
      st_nxt.led.chan = gate_out(st_nxt.out, st_nxt.seen);

      // ----------------------------------------------------------------------
      // Module indicators; bus power error darkens both
      // ----------------------------------------------------------------------
      if (i_bus.pwr_err) begin
         st_nxt.led.run = 1'b0;
         st_nxt.led.fault = 1'b0;
      end else begin
         st_nxt.led.run = i_bus.ok ? 1'b1 : st_r.blink;
         if (hw_fault) begin
            st_nxt.led.fault = 1'b1;
         end else if (i_bus.cfg_err) begin
            st_nxt.led.fault = st_r.blink;
         end else begin
            st_nxt.led.fault = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
         st_r.out <= OUT_RESET;
         st_r.blink_cnt <= BLINK_CNT_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Drive stays off until the first accepted write
   assign o_sink_on = gate_out(st_r.out, st_r.seen);
   assign o_led = st_r.led;
   assign o_wr_ack = st_r.ack;
   assign o_wr_err = st_r.err;
   assign o_id_valid = st_r.id_valid;
   assign o_id_data = st_r.id_data;
   assign o_in_len = IN_BYTES;

endmodule : dout_sink8

`default_nettype wire

// file: dout_pkg.sv
// Constants, types and helpers for the eight-channel sinking output block.
// Assumes a single 20 MHz clock and an asynchronous active-high reset.
//
// How it works
// - One output byte at offset zero is the commanded state of all eight channels.
// - No input bytes are offered; the input area length reads zero.
// - Each channel sinks its load line to ground while its bit is one.
// - Each channel's green indicator follows that channel's output bit.
// - Red fault lights on overload, short or overheat in any bus state except bus power error, which darkens it.
// - Run and fault show bus ok, bus failed, and bus power error distinctly.
// - Fault indicator flashes while a configuration error is present without a hardware fault or bus power error.
// - CANopen object index 6200h addresses the whole output byte.
// - EtherCAT index 7000h plus slot; subindices 01h..08h map channels 0..7.
`default_nettype none

package dout_pkg;

   // ----------------------------------------------------------------------
   // Sizes and addresses
   // ----------------------------------------------------------------------
   localparam int CHANNELS = 8;
   localparam logic [15:0] OUT_OFFSET = 16'h0000;
   localparam logic [7:0] OUT_RESET = 8'h00;
   localparam logic [7:0] IN_BYTES = 8'h00;
   localparam logic [15:0] CO_INDEX = 16'h6200;
   localparam logic [15:0] EC_INDEX_BASE = 16'h7000;
   localparam logic [7:0] EC_SUB_FIRST = 8'h01;
   localparam logic [7:0] EC_SUB_LAST = 8'h08;
   localparam logic [7:0] SUB_WHOLE = 8'h00;
   // Identification value is arbitrary
   localparam logic [31:0] MODULE_ID = 32'h5A3C_0E81;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int BLINK_HALF_MS = 250;
   localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
   localparam logic [31:0] BLINK_CNT_RESET = 32'h0000_0000;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      WR_IMAGE = 2'b00,
      WR_CANOPEN = 2'b01,
      WR_ETHERCAT = 2'b11
   } wr_mode_t;

   typedef struct packed {
      logic valid;
      wr_mode_t mode;
      logic [15:0] addr;
      logic [7:0] sub;
      logic [7:0] data;
   } wr_req_t;

   typedef struct packed {
      logic ok;
      logic pwr_err;
      logic cfg_err;
   } bus_stat_t;

   typedef struct packed {
      logic run;
      logic fault;
      logic [CHANNELS-1:0] chan;
   } led_t;

   // Subindex to channel number, valid only inside 01h..08h
   function automatic logic [2:0] sub_to_chan(input logic [7:0] sub);
      logic [7:0] d;
      d = sub - EC_SUB_FIRST;
      return d[2:0];
   endfunction : sub_to_chan

   function automatic logic sub_in_range(input logic [7:0] sub);
      return (sub >= EC_SUB_FIRST) && (sub <= EC_SUB_LAST);
   endfunction : sub_in_range

endpackage : dout_pkg

`default_nettype wire

// file: dout_sync.sv
// Three-stage input synchroniser with agreement filter for pin inputs.
// Assumes asynchronous inputs and the block clock domain on i_clk.
`default_nettype none

module dout_sync
   import dout_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Pin side
   input wire logic [CHANNELS-1:0] i_async,
   // Synchronised side
   output logic [CHANNELS-1:0] o_sync
);

   typedef struct packed {
      logic [CHANNELS-1:0] s1;
      logic [CHANNELS-1:0] s2;
      logic [CHANNELS-1:0] s3;
      logic [CHANNELS-1:0] q;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = i_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Only take a bit once stages two and three agree
      for (int i = 0; i < CHANNELS; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.q;

endmodule : dout_sync

`default_nettype wire

// file: dout_sink8_props.sv
// Checker for the sinking output block.
// Assumes the bind hands on BLINK_HALF.
`default_nettype none
module dout_sink8_props
   import dout_pkg::*;
#(
   parameter int BLINK_HALF = 4
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire wr_req_t i_wr,
   input wire logic [7:0] i_slot,
   input wire logic o_wr_ack,
   input wire logic o_wr_err,
   input wire logic i_id_rd,
   input wire logic o_id_valid,
   input wire logic [31:0] o_id_data,
   input wire logic [7:0] o_in_len,
   input wire bus_stat_t i_bus,
   input wire logic [CHANNELS-1:0] i_ovl_pin,
   input wire logic [CHANNELS-1:0] i_short_pin,
   input wire logic [CHANNELS-1:0] i_hot_pin,
   input wire logic [CHANNELS-1:0] o_sink_on,
   input wire led_t o_led
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   wire hw = |(i_ovl_pin | i_short_pin | i_hot_pin);
   localparam int FLASH_MAX = BLINK_HALF + 1;
   a_one_answer:
      assert property (i_wr.valid |=> o_wr_ack != o_wr_err) else $error("write answer wrong");
   a_image_byte:
      assert property (i_wr.valid && i_wr.mode == WR_IMAGE && i_wr.addr == 16'h0000
         |=> o_wr_ack && o_sink_on == $past(i_wr.data)) else $error("image byte lost");
   a_canopen_index:
      assert property (i_wr.valid && i_wr.mode == WR_CANOPEN && (i_wr.addr != 16'h6200
         || i_wr.sub != 8'h00) |=> o_wr_err) else $error("bad index taken");
   a_ecat_sub:
      assert property (i_wr.valid && i_wr.mode == WR_ETHERCAT && i_wr.addr == 16'h7000 + i_slot
         && i_wr.sub inside {[8'h01:8'h08]} |=> o_wr_ack
         && o_sink_on[$past(i_wr.sub) - 8'h01] == $past(i_wr.data[0])) else $error("channel bit lost");
   a_chan_led:
      assert property (o_led.chan == o_sink_on) else $error("channel led differs");
   a_no_inputs:
      assert property (o_in_len == 8'h00) else $error("input length not zero");
   a_id_answer:
      assert property (i_id_rd |=> o_id_valid && o_id_data == MODULE_ID) else $error("id wrong");
   a_fault_lit:
      assert property ((hw && !i_bus.pwr_err) [*5] |=> o_led.fault) else $error("fault dark");
   a_pwr_dark:
      assert property (i_bus.pwr_err |=> !o_led.run && !o_led.fault) else $error("power led lit");
   a_run_flash:
      assert property (!i_bus.ok && !i_bus.pwr_err && o_led.run
         |-> ##[1:FLASH_MAX] (!o_led.run || i_bus.ok || i_bus.pwr_err)) else $error("run not flashing");
   c_ack: cover property (o_wr_ack);
   c_err: cover property (o_wr_err);
   c_fault: cover property (o_led.fault && !i_bus.ok);
endmodule : dout_sink8_props

bind dout_sink8 dout_sink8_props #(.BLINK_HALF(BLINK_HALF)) i_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_wr(i_wr), .i_slot(i_slot), .o_wr_ack(o_wr_ack), .o_wr_err(o_wr_err), .i_id_rd(i_id_rd),
   .o_id_valid(o_id_valid), .o_id_data(o_id_data), .o_in_len(o_in_len), .i_bus(i_bus),
   .i_ovl_pin(i_ovl_pin), .i_short_pin(i_short_pin), .i_hot_pin(i_hot_pin),
   .o_sink_on(o_sink_on), .o_led(o_led));
`default_nettype wire

// file: dout_master.sv
// Bus master model issuing write requests.
// Assumes the block takes i_wr on rising edges.
`default_nettype none
module dout_master
   import dout_pkg::*;
(
   input wire logic i_clk,
   output var wr_req_t o_wr
);
   timeunit 1ns;
   timeprecision 1ns;
   initial o_wr = '0;
   // Held to the next falling edge, so one request a cycle
   task automatic put(input wr_req_t r);
      @(negedge i_clk);
      o_wr <= r;
   endtask : put
   // Released fields scrambled, never left at the last value
   task automatic rel();
      @(negedge i_clk);
      o_wr <= {1'b0, ~o_wr[33:0]};
   endtask : rel
endmodule : dout_master
`default_nettype wire

// file: dout_sink8_bench.sv
// Bench for the sinking output block.
// Assumes BLINK_HALF of 4 and a 50 ns clock.
`default_nettype none
module dout_sink8_bench
   import dout_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk, i_rst, o_wr_ack, o_wr_err, i_id_rd, o_id_valid;
   logic [7:0] i_slot, o_in_len, o_sink_on, cur;
   logic [31:0] o_id_data;
   logic [CHANNELS-1:0] ovl, shrt, hot;
   wr_req_t i_wr;
   bus_stat_t i_bus;
   led_t o_led;
   logic [8:0] q[$];
   logic [8:0] e;
   int err_total = 0, n_checks = 0, cyc = 0;
   dout_master i_bm (.i_clk(i_clk), .o_wr(i_wr));
   dout_sink8 #(.BLINK_HALF(4)) i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_slot(i_slot),
      .o_wr_ack(o_wr_ack), .o_wr_err(o_wr_err), .i_id_rd(i_id_rd), .o_id_valid(o_id_valid),
      .o_id_data(o_id_data), .o_in_len(o_in_len), .i_bus(i_bus), .i_ovl_pin(ovl),
      .i_short_pin(shrt), .i_hot_pin(hot), .o_sink_on(o_sink_on), .o_led(o_led));
   initial begin
      i_clk = 0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] g, x);
      n_checks++;
      if (g !== x) begin
         $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
         err_total++;
      end
   endtask : chk
   task automatic report_and_stop();
      chk(q.size(), 0);
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   task automatic wr(input wr_mode_t m, input logic [15:0] a, input logic [7:0] s, d);
      logic ok;
      logic [7:0] nx;
      ok = 0;
      nx = cur;
      if (m == WR_IMAGE && a == 16'h0000) {ok, nx} = {1'b1, d};
      if (m == WR_CANOPEN && a == 16'h6200 && s == 8'h00) {ok, nx} = {1'b1, d};
      if (m == WR_ETHERCAT && a == 16'h7000 + i_slot && s inside {[1:8]}) begin
         ok = 1;
         nx[s - 1] = d[0];
      end
      if (ok) cur = nx;
      q.push_back({ok, cur});
      i_bm.put({1'b1, m, a, s, d});
   endtask : wr
   task automatic idle(input int n);
      i_bm.rel();
      repeat (n - 1) @(negedge i_clk);
   endtask : idle
   task automatic watch(input logic [2:0] b, input logic [3:0] x);
      logic [1:0] r, f;
      i_bus = b;
      {r, f} = '0;
      repeat (12) begin
         @(negedge i_clk);
         r[o_led.run] = 1;
         f[o_led.fault] = 1;
      end
      chk({r, f}, x);
   endtask : watch
   // Results checked in request order; timeout ends the run
   always @(negedge i_clk) begin
      cyc++;
      if (cyc > 2000) begin
         err_total++;
         report_and_stop();
      end else begin
         chk(o_in_len, 0);
         if (o_wr_ack || o_wr_err) begin
            e = q.pop_front();
            chk({o_wr_ack, o_wr_err, o_sink_on}, {e[8], ~e[8], e[7:0]});
            chk(o_led.chan, e[7:0]);
         end
         if (o_id_valid) chk(o_id_data, MODULE_ID);
      end
   end
   initial begin
      i_rst = 1;
      {i_id_rd, i_slot, ovl, shrt, hot, cur} = '0;
      i_bus = 3'b100;
      void'($urandom(71));
      repeat (16) @(negedge i_clk);
      i_rst = 0;
      chk(o_sink_on, 0);
      wr(WR_IMAGE, 16'h0001, 0, 8'hFF);
      idle(3);
      chk(o_sink_on, 0);
      repeat (6) wr(WR_IMAGE, 0, 0, 8'($urandom));
      wr(WR_CANOPEN, 16'h6200, 0, 8'h5A);
      wr(WR_CANOPEN, 16'h6201, 0, 8'hFF);
      wr(WR_CANOPEN, 16'h6200, 1, 8'hFF);
      idle(2);
      i_slot = 8'($urandom_range(6, 1));
      for (int s = 0; s < 10; s++) wr(WR_ETHERCAT, 16'h7000 + i_slot, 8'(s), 8'($urandom));
      wr(WR_ETHERCAT, 16'h7000, 1, 1);
      wr(wr_mode_t'(2'b10), 0, 0, 8'hFF);
      i_id_rd = 1;
      idle(2);
      i_id_rd = 0;
      idle(3);
      $display("write and id tests done");
      for (int k = 0; k < 3; k++) begin
         i_bus.ok = k[0];
         {hot, shrt, ovl} = 24'h1 << (8 * k + $urandom_range(7));
         idle(6);
         chk(o_led.fault, 1);
      end
      {hot, shrt, ovl} = '0;
      idle(6);
      $display("fault tests done");
      watch(3'b000, 4'b1101);
      watch(3'b101, 4'b1011);
      watch(3'b011, 4'b0101);
      watch(3'b100, 4'b1001);
      $display("indicator tests done");
      wr(WR_IMAGE, 0, 0, 8'hC3);
      idle(2);
      i_rst = 1;
      @(negedge i_clk);
      i_rst = 0;
      cur = '0;
      chk(o_sink_on, 0);
      chk(o_led.chan, 0);
      wr(WR_CANOPEN, 16'h6200, 0, 8'hA5);
      idle(2);
      $display("reset test done");
      report_and_stop();
   end
endmodule : dout_sink8_bench
`default_nettype wire
